// File: core/fetch_retire_event_selector.sv
// Event selector for instruction fetch and retire performance conditions
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module fetch_retire_event_selector
    import perf_select_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // Pipeline conditions
    input  wire pipe_cond_t        pipe_i,
    // Counter increment
    output logic                   inc_o,
    output logic      [AMT_W-1:0]  inc_amount_o
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sel_cfg_t          cfg;
        logic              prev_active;
        logic              known;
        logic              inc;
        logic [AMT_W-1:0]  amount;
        logic [DATA_W-1:0] rdata;
    } sel_state_t;

    sel_state_t s;
    sel_state_t next_s;

    // ------------------------------------------------------------
    // Sub-event masks
    // ------------------------------------------------------------
    logic [AMT_W-1:0] walk_hits;
    logic [AMT_W-1:0] inval_hits;
    logic [AMT_W-1:0] fp_hits;
    logic [AMT_W-1:0] fast_hits;

    masked_hits #(.W(2)) u_walk (
        .vec_i   (pipe_i.itb_walk),
        .mask_i  (s.cfg.subevent_mask[1:0]),
        .count_o (walk_hits)
    );
    masked_hits #(.W(4)) u_inval (
        .vec_i   (pipe_i.ic_inval),
        .mask_i  (s.cfg.subevent_mask[3:0]),
        .count_o (inval_hits)
    );
    masked_hits #(.W(3)) u_fp (
        .vec_i   (pipe_i.ret_fp),
        .mask_i  (s.cfg.subevent_mask[2:0]),
        .count_o (fp_hits)
    );
    masked_hits #(.W(3)) u_fast (
        .vec_i   (pipe_i.ret_fastpath),
        .mask_i  (s.cfg.subevent_mask[2:0]),
        .count_o (fast_hits)
    );

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    logic [AMT_W-1:0] raw;
    logic             supported;
    logic             active;
    logic [AMT_W-1:0] gated;

    always_comb begin
        raw       = '0;
        supported = 1'b1;
        case (s.cfg.event_code_selector)
            EV_ITB_L2_HIT:    raw = AMT_W'(pipe_i.itb_l1miss_l2hit);
            EV_ITB_WALK:      raw = walk_hits;
            EV_PROBE_RESTART: raw = AMT_W'(pipe_i.probe_restart);
            EV_FETCH_STALL:   raw = AMT_W'(pipe_i.fetch_stall);
            EV_RSTACK_HIT:    raw = AMT_W'(pipe_i.rstack_hit);
            EV_RSTACK_OVF:    raw = AMT_W'(pipe_i.rstack_ovf);
            EV_IC_INVAL:      raw = inval_hits;
            EV_ITB_RELOAD:    raw = AMT_W'(pipe_i.itb_reload);
            EV_ITB_ABORT:     raw = AMT_W'(pipe_i.itb_abort);
            EV_RET_INSTR:     raw = AMT_W'(pipe_i.ret_instr) + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_UOP:       raw = AMT_W'(pipe_i.ret_uop) + AMT_W'(pipe_i.ret_assist_uop)
                                    + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_BRANCH:    raw = AMT_W'(pipe_i.ret_branch) + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_BR_MISP:   raw = AMT_W'(pipe_i.ret_br_misp) + AMT_W'(pipe_i.ret_far)
                                    + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_TAKEN:     raw = AMT_W'(pipe_i.ret_taken) + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_TAKEN_MP:  raw = AMT_W'(pipe_i.ret_taken_misp);
            EV_RET_FAR:       raw = AMT_W'(pipe_i.ret_far) + AMT_W'(pipe_i.ret_exc_int);
            EV_RET_NEAR_RET:  raw = AMT_W'(pipe_i.ret_near_ret);
            EV_RET_NRET_MP:   raw = AMT_W'(pipe_i.ret_nret_misp);
            EV_RET_IND_MP:    raw = AMT_W'(pipe_i.ret_ind_misp);
            EV_RET_FP:        raw = fp_hits;
            EV_RET_FASTPATH:  raw = fast_hits;
            EV_INT_MASKED:    raw = AMT_W'(!pipe_i.interrupt_enable_flag);
            EV_INT_MASK_PEND: raw = AMT_W'(!pipe_i.interrupt_enable_flag && pipe_i.int_pending);
            EV_INT_TAKEN:     raw = AMT_W'(pipe_i.hw_int_taken);
            EV_DEC_EMPTY:     raw = AMT_W'(pipe_i.decoder_empty);
            EV_DISP_STALL:    raw = AMT_W'(pipe_i.dispatch_stall);
            default:          supported = 1'b0;
        endcase
    end

    // rising edge only in edge mode
    rise_filter u_rise (
        .edge_mode_i   (s.cfg.edge_mode),
        .prev_active_i (s.prev_active),
        .raw_i         (raw),
        .active_o      (active),
        .amount_o      (gated)
    );

    // ------------------------------------------------------------
    // Next state and registers
    // ------------------------------------------------------------
    always_comb begin
        next_s             = s;
        next_s.prev_active = active;
        next_s.known       = supported;
        next_s.amount      = s.cfg.enable ? gated : '0;
        next_s.inc         = s.cfg.enable && (gated != '0);
        next_s.rdata       = '0;
        if (wr_i && addr_i == CTRL_OFS) begin
            next_s.cfg.event_code_selector = wdata_i[CODE_LSB +: 8];
            next_s.cfg.subevent_mask       = wdata_i[MASK_LSB +: 8];
            next_s.cfg.edge_mode           = wdata_i[EDGE_BIT];
            next_s.cfg.enable              = wdata_i[ENABLE_BIT];
        end
        if (rd_i) begin
            case (addr_i)
                CTRL_OFS: begin
                    next_s.rdata[CODE_LSB +: 8] = s.cfg.event_code_selector;
                    next_s.rdata[MASK_LSB +: 8] = s.cfg.subevent_mask;
                    next_s.rdata[EDGE_BIT]      = s.cfg.edge_mode;
                    next_s.rdata[ENABLE_BIT]    = s.cfg.enable;
                end
                STATUS_OFS: begin
                    next_s.rdata[ST_ACTIVE]            = active;
                    next_s.rdata[ST_PREV]              = s.prev_active;
                    next_s.rdata[ST_KNOWN]             = s.known;
                    next_s.rdata[ST_AMT_LSB +: AMT_W]  = s.amount;
                end
                default: next_s.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s                         <= '0;
            s.cfg.event_code_selector <= CODE_RESET;
            s.cfg.subevent_mask       <= MASK_RESET;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign rdata_o      = s.rdata;
    assign inc_o        = s.inc;
    assign inc_amount_o = s.amount;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    logic cycle_mode;
    assign cycle_mode = ce_i && s.cfg.enable && !s.cfg.edge_mode;
    logic [7:0] cur_code;
    assign cur_code = s.cfg.event_code_selector;

    sequence seq_level_low(logic c);
        ce_i && !c;
    endsequence
    sequence seq_level_high(logic c);
        ce_i && c && s.cfg.enable && s.cfg.edge_mode;
    endsequence

    chk_itb_hit_count: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_ITB_L2_HIT && pipe_i.itb_l1miss_l2hit
        |=> inc_o && inc_amount_o == 3'h1) else $error("second level hit not counted");
    chk_walk_mask_sum: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_ITB_WALK && s.cfg.subevent_mask[1:0] == 2'h3
        && pipe_i.itb_walk == 2'h3 |=> inc_amount_o == 3'h2) else $error("walk mask sum wrong");
    chk_fetch_stall: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_FETCH_STALL
        |=> inc_o == $past(pipe_i.fetch_stall)) else $error("fetch stall cycle mismatch");
    chk_inval_masked: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_IC_INVAL && s.cfg.subevent_mask[3:0] == 4'h0
        |=> !inc_o) else $error("invalidation counted with empty mask");
    chk_instr_exc: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_RET_INSTR && pipe_i.ret_instr && pipe_i.ret_exc_int
        |=> inc_amount_o == 3'h2) else $error("exception not one instruction");
    chk_far_misp: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_RET_BR_MISP && pipe_i.ret_far
        |=> inc_o) else $error("far transfer not counted mispredicted");
    chk_if_cycles: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_INT_MASKED
        |=> inc_o == !$past(pipe_i.interrupt_enable_flag)) else $error("masked cycle mismatch");
    chk_hw_int_only: assert property (
        cycle_mode && s.cfg.event_code_selector == EV_INT_TAKEN && !pipe_i.hw_int_taken
        |=> !inc_o) else $error("non hardware interrupt counted");
    chk_edge_once: assert property (
        seq_level_low(active) ##1 seq_level_high(active) ##1 seq_level_high(active)
        |-> inc_amount_o == 3'h1 ##1 inc_amount_o == 3'h0) else $error("edge count wrong");
    chk_read_timing: assert property (
        ce_i && rd_i && addr_i == CTRL_OFS |=> rdata_o[CODE_LSB +: 8] == $past(s.cfg.event_code_selector))
        else $error("read data late or wrong");

    // ------------------------------------------------------------
    // Retire and fetch checks
    // ------------------------------------------------------------
    chk_walk_4k_only: assert property (
        cycle_mode && cur_code == EV_ITB_WALK && s.cfg.subevent_mask[1:0] == 2'h1 && pipe_i.itb_walk == 2'h2
        |=> !inc_o) else $error("2M walk counted under 4K mask");
    chk_probe_restart: assert property (
        cycle_mode && cur_code == EV_PROBE_RESTART
        |=> inc_o == $past(pipe_i.probe_restart)) else $error("probe restart mismatch");
    chk_rstack_hit: assert property (
        cycle_mode && cur_code == EV_RSTACK_HIT
        |=> inc_o == $past(pipe_i.rstack_hit)) else $error("return stack hit mismatch");
    chk_rstack_ovf: assert property (
        cycle_mode && cur_code == EV_RSTACK_OVF
        |=> inc_o == $past(pipe_i.rstack_ovf)) else $error("return stack overflow mismatch");
    chk_itb_reload: assert property (
        cycle_mode && cur_code == EV_ITB_RELOAD
        |=> inc_o == $past(pipe_i.itb_reload)) else $error("reload mismatch");
    chk_uop_sources: assert property (
        cycle_mode && cur_code == EV_RET_UOP && pipe_i.ret_uop && pipe_i.ret_assist_uop && pipe_i.ret_exc_int
        |=> inc_amount_o == 3'h3) else $error("micro-op sources not summed");
    chk_branch_exc: assert property (
        cycle_mode && cur_code == EV_RET_BRANCH && pipe_i.ret_branch && pipe_i.ret_exc_int
        |=> inc_amount_o == 3'h2) else $error("exception not counted as branch");
    chk_taken_misp: assert property (
        cycle_mode && cur_code == EV_RET_TAKEN_MP
        |=> inc_o == $past(pipe_i.ret_taken_misp)) else $error("taken mispredict mismatch");
    chk_far_exc: assert property (
        cycle_mode && cur_code == EV_RET_FAR && pipe_i.ret_far && pipe_i.ret_exc_int
        |=> inc_amount_o == 3'h2) else $error("far transfer sum wrong");
    chk_near_ret: assert property (
        cycle_mode && cur_code == EV_RET_NEAR_RET
        |=> inc_o == $past(pipe_i.ret_near_ret)) else $error("near return mismatch");
    chk_ind_misp: assert property (
        cycle_mode && cur_code == EV_RET_IND_MP
        |=> inc_o == $past(pipe_i.ret_ind_misp)) else $error("indirect mispredict mismatch");
    chk_fp_classes: assert property (
        cycle_mode && cur_code == EV_RET_FP && s.cfg.subevent_mask[2:0] == 3'h7 && pipe_i.ret_fp == 3'h7
        |=> inc_amount_o == 3'h3) else $error("instruction classes not summed");
    chk_fastpath_pos: assert property (
        cycle_mode && cur_code == EV_RET_FASTPATH && s.cfg.subevent_mask[2:0] == 3'h4 && pipe_i.ret_fastpath == 3'h7
        |=> inc_amount_o == 3'h1) else $error("fastpath position mask wrong");
    chk_pend_masked: assert property (
        cycle_mode && cur_code == EV_INT_MASK_PEND && pipe_i.int_pending
        |=> inc_o == !$past(pipe_i.interrupt_enable_flag)) else $error("masked pending mismatch");
    chk_dispatch_stall: assert property (
        cycle_mode && cur_code == EV_DISP_STALL
        |=> inc_o == $past(pipe_i.dispatch_stall)) else $error("dispatch stall mismatch");
    chk_inval_sum: assert property (
        cycle_mode && cur_code == EV_IC_INVAL && s.cfg.subevent_mask[3:0] == 4'hF && pipe_i.ic_inval == 4'hF
        |=> inc_amount_o == 3'h4) else $error("invalidation kinds not summed");

    // ------------------------------------------------------------
    // Port and enable checks
    // ------------------------------------------------------------
    chk_disabled_quiet: assert property (
        ce_i && !s.cfg.enable
        |=> !inc_o && inc_amount_o == 3'h0) else $error("disabled selector counted");
    chk_rdata_idle: assert property (
        ce_i && !rd_i
        |=> rdata_o == '0) else $error("read data outside read cycle");
    chk_freeze_state: assert property (
        !ce_i
        |=> $stable(s)) else $error("state moved with enable low");
endmodule : fetch_retire_event_selector

// File: core/masked_hits.sv
// Count of set bits in a vector after a sub-event mask
`timescale 1ns/1ps
module masked_hits
    import perf_select_pkg::*;
#(
    parameter int W = 4
) (
    // Vector and mask
    input  wire logic [W-1:0]     vec_i,
    input  wire logic [W-1:0]     mask_i,
    // Result
    output logic      [AMT_W-1:0] count_o
);
    if (W < 1 || W >= (1 << AMT_W)) begin : g_bad_width
        $error("masked_hits: width out of range");
    end

    always_comb begin
        count_o = '0;
        for (int i = 0; i < W; i++) begin
            if (vec_i[i] && mask_i[i]) begin
                count_o = count_o + AMT_W'(1);
            end
        end
    end
endmodule : masked_hits

// File: core/perf_select_pkg.sv
// Constants and carrier types for the fetch and retire event selector
package perf_select_pkg;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam int        ADDR_W       = 4;
    localparam int        DATA_W       = 32;
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] STATUS_OFS  = 4'h4;
    localparam int        CODE_LSB     = 0;
    localparam int        MASK_LSB     = 8;
    localparam int        EDGE_BIT     = 16;
    localparam int        ENABLE_BIT   = 17;
    localparam int        ST_ACTIVE    = 0;
    localparam int        ST_PREV      = 1;
    localparam int        ST_KNOWN     = 2;
    localparam int        ST_AMT_LSB   = 8;
    localparam logic [7:0] CODE_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam int        AMT_W        = 3;

    // ------------------------------------------------------------
    // Event codes
    // ------------------------------------------------------------
    localparam logic [7:0] EV_ITB_L2_HIT    = 8'h84;
    localparam logic [7:0] EV_ITB_WALK      = 8'h85;
    localparam logic [7:0] EV_PROBE_RESTART = 8'h86;
    localparam logic [7:0] EV_FETCH_STALL   = 8'h87;
    localparam logic [7:0] EV_RSTACK_HIT    = 8'h88;
    localparam logic [7:0] EV_RSTACK_OVF    = 8'h89;
    localparam logic [7:0] EV_IC_INVAL      = 8'h8C;
    localparam logic [7:0] EV_ITB_RELOAD    = 8'h99;
    localparam logic [7:0] EV_ITB_ABORT     = 8'h9A;
    localparam logic [7:0] EV_RET_INSTR     = 8'hC0;
    localparam logic [7:0] EV_RET_UOP       = 8'hC1;
    localparam logic [7:0] EV_RET_BRANCH    = 8'hC2;
    localparam logic [7:0] EV_RET_BR_MISP   = 8'hC3;
    localparam logic [7:0] EV_RET_TAKEN     = 8'hC4;
    localparam logic [7:0] EV_RET_TAKEN_MP  = 8'hC5;
    localparam logic [7:0] EV_RET_FAR       = 8'hC6;
    localparam logic [7:0] EV_RET_NEAR_RET  = 8'hC8;
    localparam logic [7:0] EV_RET_NRET_MP   = 8'hC9;
    localparam logic [7:0] EV_RET_IND_MP    = 8'hCA;
    localparam logic [7:0] EV_RET_FP        = 8'hCB;
    localparam logic [7:0] EV_RET_FASTPATH  = 8'hCC;
    localparam logic [7:0] EV_INT_MASKED    = 8'hCD;
    localparam logic [7:0] EV_INT_MASK_PEND = 8'hCE;
    localparam logic [7:0] EV_INT_TAKEN     = 8'hCF;
    localparam logic [7:0] EV_DEC_EMPTY     = 8'hD0;
    localparam logic [7:0] EV_DISP_STALL    = 8'hD1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       itb_l1miss_l2hit;
        logic [1:0] itb_walk;        // 0: 4K page, 1: 2M page
        logic       probe_restart;
        logic       fetch_stall;
        logic       rstack_hit;
        logic       rstack_ovf;
        logic [3:0] ic_inval;        // probe miss, probe hit, smc miss, smc hit
        logic       itb_reload;
        logic       itb_abort;
        logic       ret_instr;
        logic       ret_exc_int;
        logic       ret_uop;
        logic       ret_assist_uop;
        logic       ret_branch;
        logic       ret_br_misp;
        logic       ret_taken;
        logic       ret_taken_misp;
        logic       ret_far;
        logic       ret_near_ret;
        logic       ret_nret_misp;
        logic       ret_ind_misp;
        logic [2:0] ret_fp;          // x87, packed integer, sse
        logic [2:0] ret_fastpath;    // low op position 0..2
        logic       interrupt_enable_flag;
        logic       int_pending;
        logic       hw_int_taken;
        logic       decoder_empty;
        logic       dispatch_stall;
    } pipe_cond_t;

    typedef struct packed {
        logic       enable;
        logic       edge_mode;
        logic [7:0] subevent_mask;
        logic [7:0] event_code_selector;
    } sel_cfg_t;

endpackage : perf_select_pkg

// File: core/rise_filter.sv
// Turns an event amount into a cycle or rising-edge count
`timescale 1ns/1ps
module rise_filter
    import perf_select_pkg::*;
(
    // Control
    input  wire logic             edge_mode_i,
    input  wire logic             prev_active_i,
    // Amount
    input  wire logic [AMT_W-1:0] raw_i,
    output logic                  active_o,
    output logic      [AMT_W-1:0] amount_o
);
    always_comb begin
        active_o = (raw_i != '0);
        if (!edge_mode_i) begin
            amount_o = raw_i;
        end else if (active_o && !prev_active_i) begin
            amount_o = AMT_W'(1);
        end else begin
            amount_o = '0;
        end
    end
endmodule : rise_filter

// File: sim/core_pipe_model.sv
// Retire-stage model that presents pipeline condition pulses to the selector
`timescale 1ns/1ps
module core_pipe_model
    import perf_select_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Conditions requested by the bench
    input  wire pipe_cond_t req_i,
    // Conditions towards the selector
    output pipe_cond_t      pipe_o
);
    // One stage register; exceptions only ever appear on ret_exc_int
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pipe_o <= '0;
        end else begin
            pipe_o <= req_i;
        end
    end
endmodule : core_pipe_model

// File: sim/tb_fetch_retire_event_selector.sv
// Self-checking bench for the fetch and retire event selector
`timescale 1ns/1ps
module tb_fetch_retire_event_selector
    import perf_select_pkg::*;
();
    typedef struct {
        logic [7:0] code;
        logic [7:0] mask;
        pipe_cond_t p;
        logic [2:0] amt;
    } row_t;

    logic              clk_i       = 1'b0;
    logic              reset_n_i   = 1'b0;
    logic              ce_i        = 1'b1;
    logic [ADDR_W-1:0] addr_i      = '0;
    logic [DATA_W-1:0] wdata_i     = '0;
    logic              wr_i        = 1'b0;
    logic              rd_i        = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    pipe_cond_t        req         = '0;
    pipe_cond_t        pipe_i;
    logic              inc_o;
    logic [AMT_W-1:0]  inc_amount_o;
    int                miscompares = 0;
    int                n_tests     = 0;
    int                cycles      = 0;
    row_t              rows[$];
    pipe_cond_t        ief_on      = '{default:0, interrupt_enable_flag:1};
    pipe_cond_t        stall_p     = '{default:0, fetch_stall:1};

    core_pipe_model pipe (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req), .pipe_o(pipe_i));

    fetch_retire_event_selector dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pipe_i(pipe_i), .inc_o(inc_o),
        .inc_amount_o(inc_amount_o)
    );

    always #10 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cfg_word(input logic [7:0] code, input logic [7:0] mask, input logic edge_m);
        return {14'h0000, 1'b1, edge_m, mask, code};
    endfunction : cfg_word

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic add(input logic [7:0] code, input logic [7:0] mask, input pipe_cond_t p, input logic [2:0] amt);
        rows.push_back('{code, mask, p, amt});
    endtask : add

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask : reg_rd

    // Drives one cycle; the output seen belongs to the drive two steps back
    task automatic step(input pipe_cond_t p, input int e);
        @(posedge clk_i);
        req <= p;
        @(negedge clk_i);
        if (e >= 0) begin
            chk(inc_amount_o, e[2:0]);
        end
    endtask : step

    task automatic summarize();
        $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        add(8'h84, 0, '{default:0, itb_l1miss_l2hit:1}, 1);
        add(8'h85, 8'h03, '{default:0, itb_walk:2'h3}, 2);
        add(8'h85, 8'h01, '{default:0, itb_walk:2'h2}, 0);
        add(8'h85, 8'hFC, '{default:0, itb_walk:2'h3}, 0);
        add(8'h86, 0, '{default:0, probe_restart:1}, 1);
        add(8'h87, 0, stall_p, 1);
        add(8'h88, 0, '{default:0, rstack_hit:1}, 1);
        add(8'h89, 0, '{default:0, rstack_ovf:1}, 1);
        add(8'h8C, 8'h0F, '{default:0, ic_inval:4'hF}, 4);
        add(8'h8C, 8'h05, '{default:0, ic_inval:4'h6}, 1);
        add(8'h8C, 8'hF0, '{default:0, ic_inval:4'hF}, 0);
        add(8'h99, 0, '{default:0, itb_reload:1}, 1);
        add(8'h9A, 0, '{default:0, itb_abort:1}, 1);
        add(8'h9A, 0, '{default:0, itb_reload:1}, 0);
        add(8'hC0, 0, '{default:0, ret_instr:1, ret_exc_int:1}, 2);
        add(8'hC0, 0, '{default:0, ret_exc_int:1}, 1);
        add(8'hC1, 0, '{default:0, ret_uop:1, ret_assist_uop:1, ret_exc_int:1}, 3);
        add(8'hC2, 0, '{default:0, ret_branch:1, ret_exc_int:1}, 2);
        add(8'hC3, 0, '{default:0, ret_br_misp:1, ret_far:1, ret_exc_int:1}, 3);
        add(8'hC4, 0, '{default:0, ret_taken:1, ret_exc_int:1}, 2);
        add(8'hC5, 0, '{default:0, ret_taken_misp:1}, 1);
        add(8'hC5, 0, '{default:0, ret_taken:1}, 0);
        add(8'hC6, 0, '{default:0, ret_far:1, ret_exc_int:1}, 2);
        add(8'hC8, 0, '{default:0, ret_near_ret:1}, 1);
        add(8'hC9, 0, '{default:0, ret_nret_misp:1}, 1);
        add(8'hCA, 0, '{default:0, ret_ind_misp:1}, 1);
        add(8'hCB, 8'h07, '{default:0, ret_fp:3'h7}, 3);
        add(8'hCB, 8'h02, '{default:0, ret_fp:3'h5}, 0);
        add(8'hCC, 8'h04, '{default:0, ret_fastpath:3'h7}, 1);
        add(8'hCD, 0, '0, 1);
        add(8'hCD, 0, ief_on, 0);
        add(8'hCE, 0, '{default:0, int_pending:1}, 1);
        add(8'hCE, 0, '{default:0, int_pending:1, interrupt_enable_flag:1}, 0);
        add(8'hCF, 0, '{default:0, hw_int_taken:1}, 1);
        add(8'hD0, 0, '{default:0, decoder_empty:1}, 1);
        add(8'hD1, 0, '{default:0, dispatch_stall:1}, 1);
        add(8'h8B, 8'hFF, '1, 0);
        repeat (10) @(posedge clk_i);
        chk(inc_o, 1'b0);
        chk(rdata_o, 32'h0);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        reg_rd(CTRL_OFS, 32'h0);
        foreach (rows[i]) begin
            @(posedge clk_i);
            addr_i  <= CTRL_OFS;
            wdata_i <= cfg_word(rows[i].code, rows[i].mask, 1'b0);
            wr_i    <= 1'b1;
            req     <= rows[i].p;
            @(posedge clk_i);
            wr_i    <= 1'b0;
            req     <= '0;
            @(posedge clk_i);
            @(negedge clk_i);
            chk(inc_amount_o, rows[i].amt); // by row
            chk(inc_o, rows[i].amt != 0); // by row
        end
        // Register port corners
        reg_wr(CTRL_OFS, 32'h0002_0387);
        reg_rd(CTRL_OFS, 32'h0002_0387);
        reg_wr(4'h8, 32'hFFFF_FFFF);
        reg_rd(4'h8, 32'h0);
        reg_wr(STATUS_OFS, 32'hFFFF_FFFF);
        reg_rd(STATUS_OFS, 32'h0000_0004);
        reg_rd(CTRL_OFS, 32'h0002_0387);
        // Disabled selector counts nothing
        reg_wr(CTRL_OFS, 32'h0000_0387);
        step(stall_p, -1);
        step('0, -1);
        step('0, 0);
        // Cycle mode then edge mode on the masked-interrupt condition
        for (int m = 0; m < 2; m++) begin
            reg_wr(CTRL_OFS, cfg_word(8'hCD, 8'h00, m[0]));
            step(ief_on, -1);
            step(ief_on, -1);
            step('0, 0);
            step('0, 0);
            step('0, 1);
            step(ief_on, (m == 1) ? 0 : 1);
        end
        // Clock enable low freezes the selector
        reg_wr(CTRL_OFS, 32'h0002_0387);
        @(posedge clk_i);
        ce_i <= 1'b0;
        req  <= stall_p;
        reg_wr(CTRL_OFS, 32'h0);
        step('0, 0);
        step('0, 0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        reg_rd(CTRL_OFS, 32'h0002_0387);
        summarize();
    end
endmodule : tb_fetch_retire_event_selector
